/* src/swr_top.sv */
`timescale 1ns/1ps
// What this block does
// - Reset outputs are asserted whenever the supply-low indication is present.
// - A triggered reset drives the active-low reset output low for about 200 ms.
// - Reset is held 200 ms after supply-low clears or manual reset goes high again.
// - A low level on the manual reset input triggers a reset pulse.
// - After the first kick edge following reset, the expiry output goes low when the kick input shows no edge for 1.6 s.
// - The watchdog timer clears during reset, while the kick is floating, and on each edge.
// - A floating kick input disables the watchdog, so it neither counts nor expires.
// - After expiry the expiry output stays low until the watchdog is cleared.
// - The expiry output is low during supply-low and goes high as soon as it clears.
// - A watchdog expiry never asserts reset by itself.
// - The active-high reset output is always the complement of the active-low one.
// - The power-fail flag is low while the comparator reports the sense input low.
// - A variant option drops the watchdog and keeps both reset outputs.
// - A brownout during a pulse in progress restarts it, so reset is held the full 200 ms after supply-low clears.
// - After reset, the first kick edge starts a fresh countdown and each edge restarts it.
module swr_top #(
  parameter int TICK_CYCLES = swr_pkg::TICK_CYCLES,
  parameter bit HAS_WATCHDOG = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Analog comparator results
  input wire logic supply_low,
  input wire logic power_fail_sense_in,
  // Board inputs
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_hiz,
  // Outputs
  output logic reset_n,
  output logic reset_out,
  output logic watchdog_expired_n,
  output logic power_fail_flag_n
);

  // ----------------------------------------------------------------
  // Internal reset
  // ----------------------------------------------------------------
  // Supply-low resets all counters at once, no clock needed
  logic arst_n;
  assign arst_n = nrst & ~supply_low;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic mr_s1_q, mr_s2_q;
  logic kick_s1_q, kick_s2_q, kick_s3_q;
  logic hiz_s1_q, hiz_s2_q;
  logic pf_s1_q, pf_s2_q;

  // Two flops per pin; the third kick flop only feeds the edge detector
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mr_s1_q <= 1'b1;
      mr_s2_q <= 1'b1;
      kick_s1_q <= 1'b0;
      kick_s2_q <= 1'b0;
      kick_s3_q <= 1'b0;
      hiz_s1_q <= 1'b1;
      hiz_s2_q <= 1'b1;
      pf_s1_q <= 1'b0;
      pf_s2_q <= 1'b0;
    end
    else
    begin
      mr_s1_q <= manual_reset_n;
      mr_s2_q <= mr_s1_q;
      kick_s1_q <= watchdog_kick_in;
      kick_s2_q <= kick_s1_q;
      kick_s3_q <= kick_s2_q;
      hiz_s1_q <= watchdog_kick_hiz;
      hiz_s2_q <= hiz_s1_q;
      pf_s1_q <= power_fail_sense_in;
      pf_s2_q <= pf_s1_q;
    end
  end

  // Edges only count while the pin is really driven
  // A rising and a falling level both count as activity
  logic kick_edge;
  assign kick_edge = (kick_s2_q ^ kick_s3_q) & ~hiz_s2_q;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [swr_pkg::PRE_W-1:0] pre_q;
  logic tick_q;

  // Free-running; a pulse may start anywhere in a tick, so it runs
  // up to one tick short of its nominal length
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end
    else if (pre_q == swr_pkg::PRE_W'(TICK_CYCLES - 1))
    begin
      pre_q <= '0;
      tick_q <= 1'b1;
    end
    else
    begin
      pre_q <= pre_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse generator
  // ----------------------------------------------------------------
  logic [swr_pkg::RST_W-1:0] rst_cnt_q;
  logic reset_n_q, reset_q;

  // Manual reset low holds the count at zero; release starts the
  // full pulse, which also swallows switch bounce
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_cnt_q <= '0;
      reset_n_q <= swr_pkg::RESET_N_RST;
      reset_q <= ~swr_pkg::RESET_N_RST;
    end
    else if (!mr_s2_q)
    begin
      rst_cnt_q <= '0;
      reset_n_q <= 1'b0;
      reset_q <= 1'b1;
    end
    else if (!reset_n_q && tick_q)
    begin
      if (rst_cnt_q == swr_pkg::RST_TICKS - 1'b1)
      begin
        reset_n_q <= 1'b1;
        reset_q <= 1'b0;
      end
      else
      begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end
    end
  end

  assign reset_n = reset_n_q;
  assign reset_out = reset_q;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [swr_pkg::WD_W-1:0] wd_cnt_q;
  logic armed_q, wdo_q;
  logic wd_clear;

  // Clear sources gathered in one term for the output; the counter repeats them in its own branches
  assign wd_clear = !reset_n_q || hiz_s2_q || kick_edge;

  // Counting starts only with the first edge after reset
  // A processor that never kicks after reset is therefore never flagged
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      armed_q <= 1'b0;
      wd_cnt_q <= '0;
    end
    else if (!HAS_WATCHDOG || !reset_n_q || hiz_s2_q)
    begin
      armed_q <= 1'b0;
      wd_cnt_q <= '0;
    end
    else if (kick_edge)
    begin
      armed_q <= 1'b1;
      wd_cnt_q <= '0;
    end
    else if (armed_q && wdo_q && tick_q)
    begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // Low from supply-low, high on the very first edge after it clears
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wdo_q <= swr_pkg::WDO_N_RST;
    else if (!HAS_WATCHDOG || wd_clear)
      wdo_q <= 1'b1;
    else if (armed_q && tick_q && wd_cnt_q == swr_pkg::WD_TICKS - 1'b1)
      wdo_q <= 1'b0;
  end

  assign watchdog_expired_n = wdo_q;

  // ----------------------------------------------------------------
  // Power-fail flag
  // ----------------------------------------------------------------
  logic pfo_q;

  // Inverted copy of the comparator, delayed by the synchroniser and one more flop
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pfo_q <= swr_pkg::PFO_N_RST;
    else
      pfo_q <= ~pf_s2_q;
  end

  assign power_fail_flag_n = pfo_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Named steps shared by the reset and watchdog properties
  sequence s_mr_held;
    !mr_s2_q ##1 !mr_s2_q;
  endsequence

  sequence s_rst_low2;
    !reset_n_q [*2];
  endsequence

  // Last tick of a live countdown with no clear pending; the variant never gets here
  sequence s_expiry;
    HAS_WATCHDOG && armed_q && tick_q && !wd_clear && wd_cnt_q == swr_pkg::WD_TICKS - 1'b1;
  endsequence

  // Reset pulse properties
  chk_rst_complement: assert property (
    @(posedge clock) disable iff (!arst_n) reset_q == !reset_n_q)
    else $error("reset outputs not complementary");

  chk_mr_holds_reset: assert property (
    @(posedge clock) disable iff (!arst_n) s_mr_held |=> s_rst_low2)
    else $error("manual reset did not hold reset low");

  chk_rst_release_len: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(reset_n_q) |-> $past(rst_cnt_q) == swr_pkg::RST_TICKS - 1'b1
      && $past(tick_q) && $past(mr_s2_q))
    else $error("reset released at wrong count");

  chk_rst_min_len: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(reset_n_q) |-> $past(rst_cnt_q) >= swr_pkg::RST_MIN_TICKS - 1'b1)
    else $error("reset pulse shorter than minimum");

  // Watchdog properties
  chk_wd_expire_at: assert property (
    @(posedge clock) disable iff (!arst_n) s_expiry |=> !wdo_q)
    else $error("watchdog did not expire at timeout");

  chk_wd_no_early: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(wdo_q) |-> $past(wd_cnt_q) == swr_pkg::WD_TICKS - 1'b1 && $past(armed_q))
    else $error("watchdog expired early");

  chk_wd_edge_clear: assert property (
    @(posedge clock) disable iff (!arst_n)
    kick_edge && reset_n_q && HAS_WATCHDOG |=> wd_cnt_q == '0 && wdo_q && armed_q)
    else $error("kick edge did not restart watchdog");

  chk_hiz_disable: assert property (
    @(posedge clock) disable iff (!arst_n)
    hiz_s2_q ##1 hiz_s2_q |-> !armed_q && wd_cnt_q == '0 && wdo_q)
    else $error("floating kick did not disable watchdog");

  chk_wdo_sticky: assert property (
    @(posedge clock) disable iff (!arst_n) !wdo_q && !wd_clear |=> !wdo_q)
    else $error("expiry output released without clear");

  chk_wd_no_reset: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(wdo_q) && mr_s2_q |-> reset_n_q ##1 reset_n_q)
    else $error("watchdog expiry asserted reset");

  chk_rst_clears_wd: assert property (
    @(posedge clock) disable iff (!arst_n) !reset_n_q |=> wdo_q && !armed_q)
    else $error("watchdog active during reset");

  // Flag, variant and timebase properties
  chk_pfo_follow: assert property (
    @(posedge clock) disable iff (!arst_n) pfo_q == !$past(pf_s2_q))
    else $error("power-fail flag does not follow comparator");

  // Looked at one cycle on, since the expiry output leaves reset low
  chk_no_wd_variant: assert property (
    @(posedge clock) disable iff (!arst_n) !HAS_WATCHDOG |=> wdo_q && !armed_q)
    else $error("watchdog active in variant without it");

  chk_tick_single: assert property (
    @(posedge clock) disable iff (!arst_n) tick_q |=> !tick_q)
    else $error("prescaler tick longer than one cycle");

endmodule

/* src/swr_pkg.sv */
package swr_pkg;
  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int PRE_W = 18;

  // ----------------------------------------------------------------
  // Reset pulse and watchdog timing, in milliseconds and in ticks
  // ----------------------------------------------------------------
  localparam int RST_PULSE_MS = 200;
  localparam int RST_MIN_MS = 140;
  localparam int WD_TIMEOUT_MS = 1600;
  localparam int RST_W = 8;
  localparam int WD_W = 11;
  localparam logic [RST_W-1:0] RST_TICKS = RST_W'(RST_PULSE_MS / TICK_MS);
  localparam logic [RST_W-1:0] RST_MIN_TICKS = RST_W'(RST_MIN_MS / TICK_MS);
  localparam logic [WD_W-1:0] WD_TICKS = WD_W'(WD_TIMEOUT_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Analog trip points, resolved outside this logic
  // ----------------------------------------------------------------
  localparam real TRIP_HI_V = 4.65;
  localparam real TRIP_LO_V = 4.40;
  localparam real PFAIL_V = 1.25;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RESET_N_RST = 1'b0;
  localparam logic WDO_N_RST = 1'b0;
  localparam logic PFO_N_RST = 1'b1;
endpackage

/* tb/swr_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Supervised processor model: kicks the watchdog pin
// ----------------------------------------------------------------
module swr_cpu_model #(
  parameter int KICK_GAP = 8
) (
  // Clock and device reset
  input wire logic clock,
  input wire logic reset_n,
  // Bench controls
  input wire logic run,
  input wire logic float_pin,
  // Kick pin and its float detector
  output logic kick,
  output logic hiz
);
  int gap_q;
  initial
  begin
    kick = 1'b0;
    hiz = 1'b0;
    gap_q = 0;
  end
  // A floating pin holds still, so only the float detector keeps the watchdog quiet
  always @(negedge clock)
  begin
    hiz <= float_pin;
    gap_q <= (gap_q + 1) % KICK_GAP;
    if (run && reset_n && !float_pin && gap_q == 0)
      kick <= ~kick; // Held in reset, the processor cannot kick
  end
endmodule

/* tb/swr_top_test.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the supervisor, ticks shortened to 4 clocks
// ----------------------------------------------------------------
module swr_top_test;
  localparam int TK = 4;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic supply_low = 1'b0;
  logic power_fail_sense_in = 1'b0;
  logic manual_reset_n = 1'b1;
  logic run = 1'b1;
  logic float_pin = 1'b0;
  logic kick, hiz, reset_n, reset_out, wdo_n, pfo_n, nw_rst_n, nw_wdo_n, nw_rst_out, nw_pfo_n;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // Full variant and watchdog-less variant share all inputs
  swr_top #(.TICK_CYCLES(TK)) dut_u (.clock(clock), .nrst(nrst), .supply_low(supply_low),
    .power_fail_sense_in(power_fail_sense_in), .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(kick), .watchdog_kick_hiz(hiz), .reset_n(reset_n),
    .reset_out(reset_out), .watchdog_expired_n(wdo_n), .power_fail_flag_n(pfo_n));
  swr_top #(.TICK_CYCLES(TK), .HAS_WATCHDOG(1'b0)) dut_nw_u (.clock(clock), .nrst(nrst),
    .supply_low(supply_low), .power_fail_sense_in(power_fail_sense_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(kick), .watchdog_kick_hiz(hiz),
    .reset_n(nw_rst_n), .reset_out(nw_rst_out), .watchdog_expired_n(nw_wdo_n),
    .power_fail_flag_n(nw_pfo_n));
  swr_cpu_model cpu_u (.clock(clock), .reset_n(reset_n), .run(run), .float_pin(float_pin),
    .kick(kick), .hiz(hiz));
  initial
  begin
    forever #2 clock = ~clock;
  end
  // Cycle ceiling: the whole sequence needs about 18200 cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task automatic chk(input string what, input logic seen, input logic exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Active-low output stays low past lo cycles and is high by hi cycles
  task automatic pulse_len(input int lo, input int hi);
    wt(lo);
    chk("reset_n held", reset_n, 1'b0);
    chk("reset_out inverse", reset_out, 1'b1);
    wt(hi - lo);
    chk("reset_n released", reset_n, 1'b1);
    chk("reset_out released", reset_out, 1'b0);
  endtask
  task automatic t_power_on();
    wt(2);
    chk("expiry high after release", wdo_n, 1'b1);
    pulse_len(780, 820);
    $display("power-on pulse done");
  endtask
  task automatic t_power_fail();
    power_fail_sense_in = 1'b1;
    wt(5);
    chk("power fail flag low", pfo_n, 1'b0);
    chk("variant power fail flag low", nw_pfo_n, 1'b0);
    power_fail_sense_in = 1'b0;
    wt(5);
    chk("power fail flag high", pfo_n, 1'b1);
    chk("variant power fail flag high", nw_pfo_n, 1'b1);
    $display("power-fail flag done");
  endtask
  task automatic t_manual();
    manual_reset_n = 1'b0;
    wt(5);
    chk("manual reset asserts", reset_n, 1'b0);
    wt(30);
    manual_reset_n = 1'b1;
    pulse_len(780, 820);
    $display("manual reset done");
  endtask
  task automatic t_watchdog();
    wt(2000);
    chk("kicked watchdog quiet", wdo_n, 1'b1);
    run = 1'b0;
    wt(6350);
    chk("expiry not early", wdo_n, 1'b1);
    wt(70);
    chk("expiry after timeout", wdo_n, 1'b0);
    chk("no reset from expiry", reset_n, 1'b1);
    chk("variant has no expiry", nw_wdo_n, 1'b1);
    chk("variant reset quiet", nw_rst_n, 1'b1);
    chk("variant reset_out quiet", nw_rst_out, 1'b0);
    wt(100);
    chk("expiry holds", wdo_n, 1'b0);
    run = 1'b1;
    wt(15);
    chk("kick clears expiry", wdo_n, 1'b1);
    $display("watchdog timeout done");
  endtask
  task automatic t_float();
    float_pin = 1'b1;
    wt(6700);
    chk("floating kick no expiry", wdo_n, 1'b1);
    float_pin = 1'b0;
    wt(20);
    $display("floating kick done");
  endtask
  task automatic t_brownout();
    supply_low = 1'b1;
    #1;
    chk("supply low resets running chip", reset_n, 1'b0);
    chk("supply low raises reset_out", reset_out, 1'b1);
    wt(5);
    supply_low = 1'b0;
    wt(5);
    manual_reset_n = 1'b0;
    wt(10);
    manual_reset_n = 1'b1;
    wt(400);
    supply_low = 1'b1;
    #1;
    chk("supply low resets", reset_n, 1'b0);
    chk("supply low expiry", wdo_n, 1'b0);
    wt(5);
    supply_low = 1'b0;
    wt(2);
    chk("expiry free at once", wdo_n, 1'b1);
    pulse_len(700, 830);
    $display("brownout done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    wt(4);
    nrst = 1'b1;
    t_power_on();
    t_power_fail();
    t_manual();
    t_watchdog();
    t_float();
    t_brownout();
    summarize();
  end
endmodule
